// >>> inc/utf_pkg.sv
/*
  Shared constants and types of the transmit endpoint flow block:
  register offsets, bit positions, response codes, result carrier and
  the packed state record of the block.
  Assumes a 32-bit APB register bus and a serial engine on the same clock.
*/
package utf_pkg;

  // ==========================================================
  // widths and register map (byte addresses)
  localparam int unsigned LEN_W  = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h10;

  // ==========================================================
  // control register fields and reset value
  localparam int unsigned CTL_W     = 4;
  localparam int unsigned CTL_ISO   = 0;
  localparam int unsigned CTL_OE    = 1;
  localparam int unsigned CTL_CEP   = 2;
  localparam int unsigned CTL_STALL = 3;
  localparam logic [CTL_W-1:0] CTL_RST = 4'h0;

  // ==========================================================
  // flag and status register fields
  localparam int unsigned FLG_OVF  = 0;
  localparam int unsigned FLG_URF  = 1;
  localparam int unsigned FLG_FULL = 2;
  localparam int unsigned FLG_EMP  = 3;
  localparam int unsigned FLG_CNT  = 6;
  localparam int unsigned ST_ACK   = 0;
  localparam int unsigned ST_ERR   = 1;
  localparam int unsigned ST_VOID  = 2;
  localparam int unsigned ST_FLUSH = 4;
  localparam logic [1:0] PKT_NONE = 2'h0;
  localparam logic [1:0] PKT_BOTH = 2'h3;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    RSP_NONE  = 2'h0,
    RSP_NAK   = 2'h1,
    RSP_STALL = 2'h2,
    RSP_DATA  = 2'h3
  } utf_rsp_t;

  typedef enum logic {
    FSM_IDLE = 1'b0,
    FSM_SEND = 1'b1
  } utf_fsm_t;

  typedef struct packed {
    logic acked;
    logic timeout;
    logic underrun;
  } utf_result_t;

  typedef struct packed {
    utf_fsm_t               fsm;
    logic [CTL_W-1:0]       ctrl;
    logic [1:0]             cnt;
    logic                   wr;
    logic                   rd;
    logic [1:0][LEN_W-1:0]  len;
    logic [LEN_W:0]         fill;
    logic                   ovf;
    logic                   urf;
    logic                   err;
    logic                   ack;
    logic                   vd;
    logic                   flush;
    logic [1:0]             p_clr;
    logic                   p_err;
    logic                   p_ack;
    logic                   p_vd;
    logic                   p_urf;
    logic                   in_seen;
    logic                   rsp_v;
    utf_rsp_t               rsp;
    logic [LEN_W-1:0]       tx_len;
    logic                   int_p;
    logic                   adv;
    logic                   rev;
    logic [DATA_W-1:0]      prdata;
    logic                   pready;
    logic                   pslverr;
  } utf_state_t;

endpackage

// >>> design/utf_tx_flow.sv
/*
  Transmit endpoint data-flow control for one USB function endpoint:
  two-packet transmit FIFO bookkeeping, status flags and the answer
  to IN tokens, with isochronous changes deferred to start of frame.
  Assumes firmware reaches it over APB and the serial engine drives
  the token, frame and result inputs synchronously on MCLK.

*/
`timescale 1ns/1ps

module utf_tx_flow #(
  parameter int unsigned FIFO_BYTES = 64
) (
  // clock and reset
  input  wire logic                              MCLK,
  input  wire logic                              RST,
  // apb slave
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [utf_pkg::ADDR_W-1:0]        PADDR,
  input  wire logic [utf_pkg::DATA_W-1:0]        PWDATA,
  output logic      [utf_pkg::DATA_W-1:0]        PRDATA,
  output logic                                   PREADY,
  output logic                                   PSLVERR,
  // serial engine events
  input  wire logic                              IN_TOKEN,
  input  wire logic                              SOF,
  input  wire logic                              SETUP_RECEIVED,
  input  wire logic                              TX_DONE,
  input  wire utf_pkg::utf_result_t              TX_RESULT,
  // answer to the serial engine
  output logic                                   RSP_VALID,
  output utf_pkg::utf_rsp_t                      RSP_CODE,
  output logic      [utf_pkg::LEN_W-1:0]         TX_LEN,
  output logic                                   TX_INT,
  output logic                                   RD_ADVANCE,
  output logic                                   RD_REVERSE
);

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [utf_pkg::ADDR_W-1:0] a,
                               input logic [utf_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  localparam logic [utf_pkg::LEN_W:0] FULL_FILL = (utf_pkg::LEN_W+1)'(FIFO_BYTES);

  utf_pkg::utf_state_t q;
  utf_pkg::utf_state_t d;

  logic access;
  logic wr_en;
  logic fifo_err;
  logic iso;
  logic avail;
  logic [utf_pkg::LEN_W:0] rd_len;

  // ==========================================================
  // shared decode
  assign access   = PSEL & PENABLE & q.pready;
  assign wr_en    = access & PWRITE;
  assign fifo_err = q.ovf | q.urf;
  assign iso      = q.ctrl[utf_pkg::CTL_ISO];
  // a slot already consumed this frame still shows in the count in
  // isochronous mode, so the pending-clear mask hides it here
  assign avail    = q.cnt[q.rd] & ~q.p_clr[q.rd];
  assign rd_len   = {1'b0, q.len[q.rd]};

  // ==========================================================
  // next state
  always_comb begin
    d         = q;
    d.rsp_v   = 1'b0;
    d.int_p   = 1'b0;
    d.adv     = 1'b0;
    d.rev     = 1'b0;

    // apb: one wait state, data and error prepared with pready
    d.pready  = PSEL & PENABLE & ~q.pready;
    d.pslverr = 1'b0;
    d.prdata  = '0;
    if (PSEL & PENABLE & ~q.pready) begin
      if (hit(PADDR, utf_pkg::OFS_CTRL)) begin
        d.prdata[utf_pkg::CTL_W-1:0] = q.ctrl;
      end else if (hit(PADDR, utf_pkg::OFS_FLAGS)) begin
        d.prdata[utf_pkg::FLG_CNT+:2]   = q.cnt;
        d.prdata[utf_pkg::FLG_EMP]      = (q.fill == '0);
        d.prdata[utf_pkg::FLG_FULL]     = (q.fill == FULL_FILL);
        d.prdata[utf_pkg::FLG_URF]      = q.urf;
        d.prdata[utf_pkg::FLG_OVF]      = q.ovf;
      end else if (hit(PADDR, utf_pkg::OFS_STAT)) begin
        d.prdata[utf_pkg::ST_FLUSH] = q.flush;
        d.prdata[utf_pkg::ST_VOID]  = q.vd;
        d.prdata[utf_pkg::ST_ERR]   = q.err;
        d.prdata[utf_pkg::ST_ACK]   = q.ack;
      end else if (!(hit(PADDR, utf_pkg::OFS_DATA) | hit(PADDR, utf_pkg::OFS_COUNT))) begin
        d.pslverr = 1'b1;
      end
    end

    // firmware clears of the sticky flags come first so that any
    // hardware set later in this process wins the same cycle
    if (wr_en && hit(PADDR, utf_pkg::OFS_CTRL)) begin
      d.ctrl = PWDATA[utf_pkg::CTL_W-1:0];
    end
    if (wr_en && hit(PADDR, utf_pkg::OFS_FLAGS)) begin
      if (PWDATA[utf_pkg::FLG_OVF]) begin
        d.ovf = 1'b0;
      end
      if (PWDATA[utf_pkg::FLG_URF]) begin
        d.urf = 1'b0;
      end
    end

    // frame start: deferred isochronous changes land here
    if (SOF) begin
      d.in_seen = 1'b0;
      d.flush   = 1'b0;
      if (iso) begin
        d.cnt   = q.cnt & ~q.p_clr;
        d.p_clr = '0;
        d.err   = q.p_err;
        d.ack   = q.p_ack;
        d.vd    = q.p_vd;
        d.p_urf = 1'b0;
        if (q.p_urf) begin
          d.urf = 1'b1;
        end
        // both packets still queued and no IN all frame: drop oldest
        if (d.cnt == utf_pkg::PKT_BOTH && !q.in_seen) begin
          d.cnt[q.rd] = 1'b0;
          d.rd        = ~q.rd;
          d.fill      = q.fill - rd_len;
          d.adv       = 1'b1;
          d.flush     = 1'b1;
        end
      end
    end

    // firmware loads a byte; a full fifo only raises overrun
    if (wr_en && hit(PADDR, utf_pkg::OFS_DATA)) begin
      if (q.fill == FULL_FILL) begin
        d.ovf = 1'b1;
      end else begin
        d.fill = d.fill + 1'b1;
      end
    end

    // byte count commits a packet into the free slot at once
    if (wr_en && hit(PADDR, utf_pkg::OFS_COUNT)) begin
      if (q.cnt == utf_pkg::PKT_BOTH) begin
        d.ovf = 1'b1;
      end else begin
        d.len[q.wr] = PWDATA[utf_pkg::LEN_W-1:0];
        d.cnt[q.wr] = 1'b1;
        d.wr        = ~q.wr;
      end
    end

    // serial engine side
    case (q.fsm)
      utf_pkg::FSM_IDLE: begin
        if (IN_TOKEN) begin
          d.in_seen = 1'b1;
          d.rsp_v   = 1'b1;
          if (iso) begin
            if (!q.ctrl[utf_pkg::CTL_OE] || fifo_err || !avail) begin
              d.rsp  = utf_pkg::RSP_NONE;
              d.p_vd = 1'b1;
              if (!q.ctrl[utf_pkg::CTL_OE]) begin
                d.p_err = 1'b0;
                d.p_ack = 1'b0;
              end
            end else begin
              d.rsp    = utf_pkg::RSP_DATA;
              d.tx_len = q.len[q.rd];
              d.fsm    = utf_pkg::FSM_SEND;
            end
          end else if (q.ctrl[utf_pkg::CTL_CEP] && SETUP_RECEIVED) begin
            // setup pending outranks the stall bit
            d.rsp = utf_pkg::RSP_NAK;
            d.vd  = 1'b1;
          end else if (fifo_err) begin
            d.rsp = utf_pkg::RSP_NAK;
            d.vd  = 1'b1;
          end else if (q.ctrl[utf_pkg::CTL_STALL]) begin
            d.rsp = utf_pkg::RSP_STALL;
            d.vd  = 1'b1;
          end else if (!q.ctrl[utf_pkg::CTL_OE] || !avail) begin
            d.rsp = utf_pkg::RSP_NAK;
            d.vd  = 1'b1;
          end else begin
            d.rsp    = utf_pkg::RSP_DATA;
            d.tx_len = q.len[q.rd];
            d.fsm    = utf_pkg::FSM_SEND;
          end
        end
      end
      utf_pkg::FSM_SEND: begin
        if (TX_DONE) begin
          d.fsm = utf_pkg::FSM_IDLE;
          if (iso) begin
            // no handshake in isochronous mode: marker always moves
            d.rd           = ~q.rd;
            d.p_clr[q.rd]  = 1'b1;
            d.fill         = d.fill - rd_len;
            d.adv          = 1'b1;
            d.p_vd         = 1'b0;
            if (TX_RESULT.underrun) begin
              d.p_err = 1'b1;
              d.p_ack = 1'b0;
              d.p_urf = 1'b1;
            end else begin
              d.p_err = 1'b0;
              d.p_ack = 1'b1;
            end
          end else begin
            d.int_p = 1'b1;
            d.vd    = 1'b0;
            if (TX_RESULT.underrun) begin
              d.err = 1'b1;
              d.ack = 1'b0;
              d.urf = 1'b1;
              d.rev = 1'b1;
            end else if (TX_RESULT.acked) begin
              d.err        = 1'b0;
              d.ack        = 1'b1;
              d.cnt[q.rd]  = 1'b0;
              d.rd         = ~q.rd;
              d.fill       = d.fill - rd_len;
              d.adv        = 1'b1;
            end else begin
              d.err = 1'b1;
              d.ack = 1'b0;
              d.rev = 1'b1;
            end
          end
        end
      end
      default: begin
        d.fsm = utf_pkg::FSM_IDLE;
      end
    endcase

    // outside isochronous mode the shadow flags simply follow the
    // visible ones, so a later switch to isochronous starts clean
    if (!iso) begin
      d.p_err = d.err;
      d.p_ack = d.ack;
      d.p_vd  = d.vd;
      d.p_urf = 1'b0;
      d.p_clr = '0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      q      <= '0;
      q.ctrl <= utf_pkg::CTL_RST;
      q.fsm  <= utf_pkg::FSM_IDLE;
      q.rsp  <= utf_pkg::RSP_NONE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign PRDATA     = q.prdata;
  assign PREADY     = q.pready;
  assign PSLVERR    = q.pslverr;
  assign RSP_VALID  = q.rsp_v;
  assign RSP_CODE   = q.rsp;
  assign TX_LEN     = q.tx_len;
  assign TX_INT     = q.int_p;
  assign RD_ADVANCE = q.adv;
  assign RD_REVERSE = q.rev;

endmodule

// >>> dv/utf_host_model.sv
/* host-side stand-in: turns each data answer into a transmit result.
   assumes the bench sets res and dly before each token. */
`timescale 1ns/1ps
module utf_host_model (
  // clock and reset
  input  wire logic                 MCLK,
  input  wire logic                 RST,
  // answer from the block
  input  wire logic                 RSP_VALID,
  input  wire utf_pkg::utf_rsp_t    RSP_CODE,
  // result chosen by the bench
  input  wire utf_pkg::utf_result_t res,
  input  wire logic [3:0]           dly,
  // result to the block
  output logic                      TX_DONE,
  output utf_pkg::utf_result_t      TX_RESULT
);
  logic [3:0] cnt_q;
  logic       run_q;
  // ==========================================
  // result after a data answer; the result lines toggle when not valid
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      {TX_DONE, run_q, cnt_q} <= '0;
      TX_RESULT <= '0;
    end else begin
      TX_DONE <= 1'b0;
      TX_RESULT <= ~TX_RESULT;
      if (RSP_VALID && RSP_CODE == utf_pkg::RSP_DATA) begin
        run_q <= 1'b1;
        cnt_q <= dly;
      end else if (run_q && cnt_q == 4'h0) begin
        run_q <= 1'b0;
        TX_DONE <= 1'b1;
        TX_RESULT <= res;
      end else if (run_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// >>> dv/utf_tx_flow_props.sv
/* port checker of the transmit flow block.
   assumes binding to utf_tx_flow and the single MCLK domain. */
`timescale 1ns/1ps
module utf_tx_flow_props #(
  parameter int unsigned FIFO_BYTES = 64
) (
  input wire logic                 MCLK,
  input wire logic                 RST,
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PREADY,
  input wire logic                 PSLVERR,
  input wire logic                 IN_TOKEN,
  input wire logic                 TX_DONE,
  input wire utf_pkg::utf_result_t TX_RESULT,
  input wire logic                 RSP_VALID,
  input wire utf_pkg::utf_rsp_t    RSP_CODE,
  input wire logic                 TX_INT,
  input wire logic                 RD_ADVANCE,
  input wire logic                 RD_REVERSE
);
  logic busy_q;
  // ==========================================
  // a data answer waits for its result; tokens then are ignored
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) busy_q <= 1'b0;
    else if (RSP_VALID && RSP_CODE == utf_pkg::RSP_DATA) busy_q <= 1'b1;
    else if (TX_DONE) busy_q <= 1'b0;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  a_token_answer:
    assert property (IN_TOKEN && !busy_q && !RSP_VALID && !$past(IN_TOKEN) |=> RSP_VALID) else $error("token unanswered");
  a_answer_pulse:
    assert property (RSP_VALID |=> !RSP_VALID) else $error("answer longer than one cycle");
  a_answer_cause:
    assert property (RSP_VALID |-> $past(IN_TOKEN)) else $error("answer without token");
  a_int_cause:
    assert property (TX_INT |-> $past(TX_DONE) && $past(busy_q)) else $error("interrupt without result");
  a_reverse_cause:
    assert property (RD_REVERSE |-> $past(TX_DONE) && ($past(TX_RESULT.underrun) || !$past(TX_RESULT.acked)))
      else $error("reverse without failed send");
  a_ack_advance:
    assert property (TX_DONE && busy_q && TX_RESULT.acked && !TX_RESULT.underrun |=> RD_ADVANCE && !RD_REVERSE)
      else $error("acked send did not advance");
  a_apb_ready:
    assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |=> PREADY) else $error("ready not in second access cycle");
  a_ready_pulse:
    assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  a_slverr_ready:
    assert property (PSLVERR |-> PREADY) else $error("error without ready");
  c_data_sent: cover property (RSP_VALID && RSP_CODE == utf_pkg::RSP_DATA);
  c_reverse: cover property (RD_REVERSE);
  c_slverr: cover property (PSLVERR);
endmodule
bind utf_tx_flow utf_tx_flow_props #(.FIFO_BYTES(FIFO_BYTES)) u_props (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .IN_TOKEN(IN_TOKEN), .TX_DONE(TX_DONE),
  .TX_RESULT(TX_RESULT), .RSP_VALID(RSP_VALID), .RSP_CODE(RSP_CODE), .TX_INT(TX_INT),
  .RD_ADVANCE(RD_ADVANCE), .RD_REVERSE(RD_REVERSE));

// >>> dv/utf_tx_flow_bench.sv
/* self-checking bench of the transmit flow block.
   assumes the host model answers data packets on the same clock. */
`timescale 1ns/1ps
module utf_tx_flow_bench;
  logic                 MCLK, RST, PSEL, PENABLE, PWRITE, IN_TOKEN, SOF, SETUP_RECEIVED, TX_DONE;
  logic                 PREADY, PSLVERR, RSP_VALID, TX_INT, RD_ADVANCE, RD_REVERSE;
  logic [7:0]           PADDR, TX_LEN;
  logic [31:0]          PWDATA, PRDATA;
  logic [3:0]           dly;
  utf_pkg::utf_rsp_t    RSP_CODE;
  utf_pkg::utf_result_t TX_RESULT, res;
  logic [32:0]          rd_q[$], mk_q[$];
  logic [9:0]           rs_q[$];
  logic [2:0]           ev_q[$];
  int                   lq[$];
  int                   failures, checked;
  utf_tx_flow dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IN_TOKEN(IN_TOKEN), .SOF(SOF),
    .SETUP_RECEIVED(SETUP_RECEIVED), .TX_DONE(TX_DONE), .TX_RESULT(TX_RESULT), .RSP_VALID(RSP_VALID),
    .RSP_CODE(RSP_CODE), .TX_LEN(TX_LEN), .TX_INT(TX_INT), .RD_ADVANCE(RD_ADVANCE), .RD_REVERSE(RD_REVERSE));
  utf_host_model u_host (.MCLK(MCLK), .RST(RST), .RSP_VALID(RSP_VALID), .RSP_CODE(RSP_CODE), .res(res),
    .dly(dly), .TX_DONE(TX_DONE), .TX_RESULT(TX_RESULT));
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // monitor: oldest note is compared whenever a result shows
  always @(posedge MCLK) begin
    if (PSEL && PENABLE && PREADY && !PWRITE) chk({PSLVERR, PRDATA} & mk_q.pop_front(), rd_q.pop_front());
    if (RSP_VALID) chk({RSP_CODE, RSP_CODE == utf_pkg::RSP_DATA ? TX_LEN : 8'h00}, 33'(rs_q.pop_front()));
    if (TX_INT || RD_ADVANCE || RD_REVERSE) chk(33'({TX_INT, RD_ADVANCE, RD_REVERSE}), 33'(ev_q.pop_front()));
  end
  // apb master; a read notes its masked expectation, reads above 8'h10 expect the error
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    if (!w) begin
      mk_q.push_back({1'b1, m});
      rd_q.push_back({a > 8'h10, d & m});
    end
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (!PREADY);
    // one idle edge so a following call never re-drives psel in this step
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic load();
    int l;
    l = $urandom_range(8, 1);
    repeat (l) apb(1'b1, utf_pkg::OFS_DATA, $urandom, 32'h0);
    lq.push_back(l);
    apb(1'b1, utf_pkg::OFS_COUNT, 32'(l), 32'h0);
  endtask
  // token with its expected answer and read-marker events
  task automatic tok(input utf_pkg::utf_rsp_t c, input logic [2:0] ev);
    int n;
    dly = 4'($urandom_range(6, 0));
    rs_q.push_back({c, c == utf_pkg::RSP_DATA ? 8'(lq[0]) : 8'h00});
    if (ev != 3'h0) ev_q.push_back(ev);
    IN_TOKEN <= 1'b1;
    @(posedge MCLK);
    IN_TOKEN <= 1'b0;
    for (n = 0; c == utf_pkg::RSP_DATA && !TX_DONE && n < 40; n++) @(posedge MCLK);
    repeat (3) @(posedge MCLK);
    if (ev[1]) void'(lq.pop_front());
  endtask
  task automatic sof();
    SOF <= 1'b1;
    @(posedge MCLK);
    SOF <= 1'b0;
    repeat (2) @(posedge MCLK);
  endtask
  initial begin
    #300us;
    failures++;
    summarize();
  end
  // ==========================================
  // main sequence
  initial begin
    {PSEL, PENABLE, PWRITE, IN_TOKEN, SOF, SETUP_RECEIVED} = '0;
    {PADDR, PWDATA, res, dly, failures, checked} = '0;
    RST = 1'b1;
    void'($urandom(13));
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    apb(1'b0, utf_pkg::OFS_CTRL, 32'h0, 32'hf);
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'h08, 32'hcf);
    apb(1'b0, utf_pkg::OFS_STAT, 32'h0, 32'h17);
    apb(1'b0, 8'h20, 32'h0, 32'hffffffff);
    apb(1'b1, utf_pkg::OFS_CTRL, 32'h2, 32'h0);
    tok(utf_pkg::RSP_NAK, 3'h0);
    apb(1'b0, utf_pkg::OFS_STAT, 32'h4, 32'h7);
    load();
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'h40, 32'hc0);
    load();
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'hc0, 32'hc0);
    apb(1'b1, utf_pkg::OFS_COUNT, 32'h4, 32'h0);
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'hc1, 32'hc3);
    tok(utf_pkg::RSP_NAK, 3'h0);
    apb(1'b1, utf_pkg::OFS_FLAGS, 32'h1, 32'h0);
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'hc0, 32'hc3);
    res = '{1'b0, 1'b1, 1'b0};
    tok(utf_pkg::RSP_DATA, 3'b101);
    apb(1'b0, utf_pkg::OFS_STAT, 32'h2, 32'h7);
    res = '{1'b1, 1'b0, 1'b0};
    tok(utf_pkg::RSP_DATA, 3'b110);
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'h80, 32'hc0);
    tok(utf_pkg::RSP_DATA, 3'b110);
    apb(1'b1, utf_pkg::OFS_CTRL, 32'he, 32'h0);
    load();
    SETUP_RECEIVED <= 1'b1;
    tok(utf_pkg::RSP_NAK, 3'h0);
    apb(1'b0, utf_pkg::OFS_STAT, 32'h5, 32'h7);
    SETUP_RECEIVED <= 1'b0;
    tok(utf_pkg::RSP_STALL, 3'h0);
    apb(1'b1, utf_pkg::OFS_CTRL, 32'h2, 32'h0);
    res = '{1'b0, 1'b0, 1'b1};
    tok(utf_pkg::RSP_DATA, 3'b101);
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'h42, 32'hc3);
    tok(utf_pkg::RSP_NAK, 3'h0);
    apb(1'b0, utf_pkg::OFS_STAT, 32'h6, 32'h7);
    apb(1'b1, utf_pkg::OFS_FLAGS, 32'h2, 32'h0);
    res = '{1'b1, 1'b0, 1'b0};
    tok(utf_pkg::RSP_DATA, 3'b110);
    apb(1'b1, utf_pkg::OFS_CTRL, 32'h3, 32'h0);
    tok(utf_pkg::RSP_NONE, 3'h0);
    apb(1'b0, utf_pkg::OFS_STAT, 32'h1, 32'h7);
    sof();
    apb(1'b0, utf_pkg::OFS_STAT, 32'h5, 32'h7);
    load();
    res = '{1'b0, 1'b1, 1'b0};
    tok(utf_pkg::RSP_DATA, 3'b010);
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'h80, 32'hc0);
    sof();
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'h00, 32'hc0);
    apb(1'b0, utf_pkg::OFS_STAT, 32'h1, 32'h7);
    load();
    res = '{1'b0, 1'b0, 1'b1};
    tok(utf_pkg::RSP_DATA, 3'b010);
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'h40, 32'hc2);
    sof();
    apb(1'b0, utf_pkg::OFS_FLAGS, 32'h02, 32'hc2);
    apb(1'b0, utf_pkg::OFS_STAT, 32'h2, 32'h7);
    load();
    tok(utf_pkg::RSP_NONE, 3'h0);
    summarize();
  end
endmodule
